/* File: spi_master_model.sv */
// Behavioural mode 0 SPI master that plays the host controller.
`timescale 1ns/1ps
module spi_master_model (
    input  wire logic clk_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o,
    input  wire logic so_i
);
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end

    task automatic half();
        repeat (4) @(posedge clk_i);
    endtask : half

    // Shifts nb bits of tx and gathers SO; keep leaves the frame open.
    task automatic xfer(input logic [31:0] tx, input int nb, input logic keep,
                        output logic [31:0] rx);
        rx = 32'h0;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            si_o <= tx[i];
            half();
            sck_o <= 1'b1;
            rx = {rx[30:0], so_i};
            half();
            sck_o <= 1'b0;
        end
        if (!keep) begin
            half();
            cs_n_o <= 1'b1;
            si_o   <= ~si_o;
            repeat (3) half();
        end
    endtask : xfer
endmodule : spi_master_model

/* File: spi_nvsram_cmd_status_protect.sv */
// Serial nvSRAM opcode decoder, status register, write guarding and write buffer.
`timescale 1ns/1ps
`include "spi_nvsram_map.svh"

module fifo_buf #(
    parameter int WIDTH = 23,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp;
    logic [AW:0]      rp;

    assign in_ready_o  = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
    assign out_valid_o = (wp != rp);
    assign out_data_o  = mem[rp[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (in_valid_i && in_ready_o) begin
            mem[wp[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (in_valid_i && in_ready_o) begin
                wp <= wp + 1'b1;
            end
            if (out_valid_o && out_ready_i) begin
                rp <= rp + 1'b1;
            end
        end
    end
endmodule : fifo_buf

// Function
// - Active while selected, standby after save/restore ends.
// - Instruction starts at select fall, MSB first.
// - 06h sets, 04h clears write enable.
// - 05h reads, 01h writes status register.
// - 03h reads, 02h writes memory array.
// - 3Ch saves, 60h restores nonvolatile copy.
// - Ten opcodes; 59h/19h autosave; 1Eh reserved.
// - Status: pin guard, spare, guards, latch, busy.
// - Busy bit follows save/restore, read only.
// - Status read shifts status out on SO.
// - Status write takes eight bits, needs latch.
// - Status write changes only bits 7, 3, 2.
// - Spare bits cleared at power-up, read zero.
// - Guard, spare and latch bits start zero.
// - Write enable latch cleared at power-up.
// - Write-class opcodes ignored while latch clear.
// - Write enable opcode sets the latch.
// - Completed write-class instruction clears the latch.
// - Write disable clears latch at select rise.
// - Status becomes nonvolatile only by save.
// - Guard bits protect quarter, half or all.
// - Pin guard enable gates the guard pin.
// - Low guard pin with enable rejects status write.
// - Unknown opcode ignores input, SO stays off.
// - Sample SI on rising, drive SO falling.
// - Guarded burst writes skip data, address advances.
module spi_nvsram_cmd_status_protect
    import spi_nvsram_pkg::*;
#(
    parameter logic AUTOSAVE_DEFAULT = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        cs_n_i,
    input  wire logic        sck_i,
    input  wire logic        si_i,
    input  wire logic        guard_pin_n_i,
    output logic             so_o,
    output logic             so_oe_n_o,
    output logic             active_o,
    output logic             standby_o,
    input  wire logic        nv_busy_i,
    output logic             save_req_o,
    output logic             restore_req_o,
    output logic             autosave_en_o,
    output status_t          nv_status_o,
    input  wire status_t     restore_status_i,
    input  wire logic        restore_load_i,
    output logic             mem_rd_req_o,
    output logic [14:0]      mem_rd_addr_o,
    input  wire logic [7:0]  mem_rd_data_i,
    output logic             mem_wr_valid_o,
    output mem_wr_t          mem_wr_o,
    input  wire logic        mem_wr_ready_i,
    output logic             wr_overflow_o
);
    pins_t       sync1;
    pins_t       sync2;
    logic        sck_d;
    logic        cs_d;
    state_t      state;
    logic [7:0]  op;
    logic [2:0]  bit_cnt;
    logic [7:0]  rx_sh;
    logic        addr_hi_done;
    logic [14:0] addr;
    logic [14:0] next_addr;
    logic [7:0]  tx_sh;
    logic        rd_pend;
    logic        committed;
    logic        guard_ok;
    logic        pin_guard;
    logic        guard_hi;
    logic        guard_lo;
    logic        wel;
    logic        busy;
    status_t     status;
    logic        wr_push;
    mem_wr_t     wr_word;
    logic        fifo_in_ready;
    logic        fifo_valid;
    logic        fifo_ready;
    mem_wr_t     fifo_data;
    logic        sck_rise;
    logic        sck_fall;
    logic        cs_rise;
    logic        cs_fall;
    logic        byte_done;
    logic        tx_on;
    logic [7:0]  rx_byte;

    function automatic logic guarded(input logic [14:0] a, input logic hi, input logic lo);
        case ({hi, lo})
            2'b00:   guarded = 1'b0;
            2'b01:   guarded = (a >= `GUARD_QUARTER_BASE);
            2'b10:   guarded = (a >= `GUARD_HALF_BASE);
            default: guarded = 1'b1;
        endcase
    endfunction : guarded

    // Pins cross into the clock domain through two flip-flops.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, guard_n: 1'b1};
            sync2 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, guard_n: 1'b1};
            sck_d <= 1'b0;
            cs_d  <= 1'b1;
        end else begin
            sync1 <= '{cs_n: cs_n_i, sck: sck_i, si: si_i, guard_n: guard_pin_n_i};
            sync2 <= sync1;
            sck_d <= sync2.sck;
            cs_d  <= sync2.cs_n;
        end
    end

    assign sck_rise  = sync2.sck && !sck_d;
    assign sck_fall  = !sync2.sck && sck_d;
    assign cs_fall   = cs_d && !sync2.cs_n;
    assign cs_rise   = !cs_d && sync2.cs_n;
    assign rx_byte   = {rx_sh[6:0], sync2.si};
    assign byte_done = sck_rise && (bit_cnt == `LAST_BIT_IDX) && !cs_rise &&
                       (state != ST_IDLE) && (state != ST_IGNORE);
    assign tx_on     = (state == ST_STAT_R) || (state == ST_RDATA);
    assign next_addr = (state == ST_ADDR) ? {addr[14:8], rx_byte} : addr + 15'h0001;
    assign status    = '{pin_guard: pin_guard, spare: 3'h0, guard_hi: guard_hi,
                         guard_lo: guard_lo, wel: wel, busy: busy};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bit_cnt <= 3'h0;
            rx_sh   <= 8'h00;
        end else if (cs_fall) begin
            bit_cnt <= 3'h0;
        end else if (sck_rise && !sync2.cs_n) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_sh   <= rx_byte;
        end
    end

    // Decoder: one opcode per select, unknown codes park in ST_IGNORE.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
        end else if (cs_rise) begin
            state <= ST_IDLE;
        end else if (cs_fall) begin
            state <= ST_OPCODE;
        end else if (byte_done) begin
            case (state)
                ST_OPCODE: begin
                    case (rx_byte)
                        `OP_STAT_READ:  state <= ST_STAT_R;
                        `OP_STAT_WRITE: state <= wel ? ST_STAT_W : ST_IGNORE;
                        `OP_MEM_READ:   state <= ST_ADDR;
                        `OP_MEM_WRITE:  state <= wel ? ST_ADDR : ST_IGNORE;
                        default:        state <= ST_IGNORE;
                    endcase
                end
                ST_ADDR: begin
                    if (addr_hi_done) begin
                        state <= (op == `OP_MEM_WRITE) ? ST_WDATA : ST_RDATA;
                    end
                end
                ST_STAT_W: state <= ST_IGNORE;
                default:   state <= state;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op           <= 8'h00;
            addr_hi_done <= 1'b0;
            addr         <= 15'h0000;
        end else if (cs_fall) begin
            addr_hi_done <= 1'b0;
        end else if (byte_done) begin
            if (state == ST_OPCODE) begin
                op <= rx_byte;
            end
            if (state == ST_ADDR && !addr_hi_done) begin
                addr[14:8]   <= rx_byte[6:0];
                addr_hi_done <= 1'b1;
            end else if (state == ST_ADDR || tx_on || state == ST_WDATA) begin
                addr <= next_addr;
            end
        end
    end

    // Marks an accepted write-class instruction whose latch clear waits for select rise.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            committed <= 1'b0;
        end else if (cs_fall) begin
            committed <= 1'b0;
        end else if (byte_done) begin
            if (state == ST_OPCODE) begin
                committed <= (rx_byte == `OP_WR_DISABLE) ||
                             (wel && (rx_byte == `OP_NV_SAVE || rx_byte == `OP_NV_RESTORE ||
                              rx_byte == `OP_AUTOSAVE_ON || rx_byte == `OP_AUTOSAVE_OFF));
            end else if (state == ST_STAT_W || state == ST_WDATA) begin
                committed <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wel <= 1'b0;
        end else if (cs_rise && committed) begin
            wel <= 1'b0;
        end else if (byte_done && state == ST_OPCODE && rx_byte == `OP_WR_ENABLE) begin
            wel <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            guard_ok <= 1'b1;
        end else if (cs_fall) begin
            guard_ok <= !(pin_guard && !sync2.guard_n);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_guard <= 1'b0;
            guard_hi  <= 1'b0;
            guard_lo  <= 1'b0;
        end else if (byte_done && state == ST_STAT_W && guard_ok) begin
            pin_guard <= rx_byte[`ST_PIN_GUARD_BIT];
            guard_hi  <= rx_byte[`ST_GUARD_HI_BIT];
            guard_lo  <= rx_byte[`ST_GUARD_LO_BIT];
        end else if (restore_load_i) begin
            pin_guard <= restore_status_i.pin_guard;
            guard_hi  <= restore_status_i.guard_hi;
            guard_lo  <= restore_status_i.guard_lo;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy          <= 1'b0;
            save_req_o    <= 1'b0;
            restore_req_o <= 1'b0;
            autosave_en_o <= AUTOSAVE_DEFAULT;
            nv_status_o   <= `ST_RESET;
        end else begin
            busy          <= nv_busy_i || save_req_o || restore_req_o;
            save_req_o    <= cs_rise && committed && op == `OP_NV_SAVE;
            restore_req_o <= cs_rise && committed && op == `OP_NV_RESTORE;
            nv_status_o   <= status;
            if (cs_rise && committed && op == `OP_AUTOSAVE_ON) begin
                autosave_en_o <= 1'b1;
            end else if (cs_rise && committed && op == `OP_AUTOSAVE_OFF) begin
                autosave_en_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_o  <= 1'b0;
            standby_o <= 1'b1;
        end else begin
            active_o  <= !sync2.cs_n;
            standby_o <= sync2.cs_n && cs_d && !busy && !nv_busy_i &&
                         !save_req_o && !restore_req_o;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_rd_req_o  <= 1'b0;
            mem_rd_addr_o <= 15'h0000;
            rd_pend       <= 1'b0;
        end else begin
            mem_rd_req_o <= byte_done && ((state == ST_ADDR && addr_hi_done &&
                            op == `OP_MEM_READ) || state == ST_RDATA);
            rd_pend      <= mem_rd_req_o;
            if (byte_done) begin
                mem_rd_addr_o <= next_addr;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_sh <= 8'h00;
            so_o  <= 1'b0;
        end else if (byte_done && ((state == ST_OPCODE && rx_byte == `OP_STAT_READ) ||
                                   state == ST_STAT_R)) begin
            tx_sh <= status;
        end else if (rd_pend) begin
            tx_sh <= mem_rd_data_i;
        end else if (sck_fall && tx_on) begin
            so_o  <= tx_sh[7];
            tx_sh <= {tx_sh[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            so_oe_n_o <= 1'b1;
        end else begin
            so_oe_n_o <= !(tx_on && !sync2.cs_n);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_push       <= 1'b0;
            wr_word       <= '0;
            wr_overflow_o <= 1'b0;
        end else begin
            wr_push <= byte_done && state == ST_WDATA && !guarded(addr, guard_hi, guard_lo);
            wr_word <= '{addr: addr, data: rx_byte};
            if (wr_push && !fifo_in_ready) begin
                wr_overflow_o <= 1'b1;
            end else if (cs_fall) begin
                wr_overflow_o <= 1'b0;
            end
        end
    end

    fifo_buf #(
        .WIDTH ($bits(mem_wr_t)),
        .DEPTH (`FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (wr_push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (wr_word),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_ready),
        .out_data_o  (fifo_data)
    );

    assign fifo_ready = !mem_wr_valid_o || mem_wr_ready_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_wr_valid_o <= 1'b0;
            mem_wr_o       <= '0;
        end else if (fifo_ready) begin
            mem_wr_valid_o <= fifo_valid;
            mem_wr_o       <= fifo_data;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    AST_ACTIVE_MODE: assert property (!sync2.cs_n |=> active_o && !standby_o)
        else $error("Selected device is not in active mode.");
    AST_WEL_SET: assert property (
        byte_done && state == ST_OPCODE && rx_byte == `OP_WR_ENABLE |=> wel)
        else $error("Write enable opcode did not set the latch.");
    AST_WEL_CLEAR: assert property (cs_rise && committed |=> !wel)
        else $error("Latch survived a completed write-class instruction.");
    AST_IGNORE_LOCKED: assert property (
        byte_done && state == ST_OPCODE && !wel &&
        (rx_byte == `OP_STAT_WRITE || rx_byte == `OP_MEM_WRITE) |=> state == ST_IGNORE)
        else $error("Write-class opcode accepted with latch clear.");
    AST_RESERVED_OP: assert property (
        byte_done && state == ST_OPCODE && rx_byte == `OP_RESERVED |=> state == ST_IGNORE)
        else $error("Reserved opcode was not ignored.");
    AST_SO_OFF: assert property (state == ST_IGNORE |=> so_oe_n_o)
        else $error("SO driven after an ignored opcode.");
    AST_BUSY_FOLLOW: assert property (nv_busy_i |=> busy ##1 nv_status_o.busy)
        else $error("Busy bit missed a running save or restore.");
    AST_SPARE_ZERO: assert property (nv_status_o.spare == 3'h0)
        else $error("Spare status bits are not zero.");
    AST_STATUS_WRITE_CMD_KEEP_WEL: assert property (
        byte_done && state == ST_STAT_W |=> wel && $stable(wel))
        else $error("Status write altered the latch.");
    AST_PIN_GUARD: assert property (
        byte_done && state == ST_STAT_W && !guard_ok && !restore_load_i
        |=> $stable(pin_guard) && $stable(guard_hi) && $stable(guard_lo))
        else $error("Guarded status write was applied.");
    AST_NO_GUARDED_PUSH: assert property (wr_push |-> !guarded(wr_word.addr, guard_hi, guard_lo))
        else $error("Write into a guarded range reached the buffer.");
    AST_SAVE_AFTER_RISE: assert property (save_req_o |-> $past(cs_rise) && !wel)
        else $error("Save request not tied to select rise.");

    COV_STATUS_READ: cover property (state == ST_STAT_R ##[1:300] sck_fall);
    COV_WRITE_PUSH: cover property (wr_push ##[1:20] mem_wr_valid_o);
    COV_SAVE: cover property (save_req_o ##[1:8] standby_o);
endmodule : spi_nvsram_cmd_status_protect

/* File: spi_nvsram_map.svh */
// Opcodes, status layout, guard bounds and sizes of the serial nvSRAM command block.
`ifndef SPI_NVSRAM_MAP_SVH
`define SPI_NVSRAM_MAP_SVH

`define OP_WR_ENABLE    8'h06
`define OP_WR_DISABLE   8'h04
`define OP_STAT_READ    8'h05
`define OP_STAT_WRITE   8'h01
`define OP_MEM_READ     8'h03
`define OP_MEM_WRITE    8'h02
`define OP_NV_SAVE      8'h3C
`define OP_NV_RESTORE   8'h60
`define OP_AUTOSAVE_ON  8'h59
`define OP_AUTOSAVE_OFF 8'h19
`define OP_RESERVED     8'h1E

`define ST_PIN_GUARD_BIT 7
`define ST_GUARD_HI_BIT  3
`define ST_GUARD_LO_BIT  2
`define ST_WEL_BIT       1
`define ST_BUSY_BIT      0
`define ST_RESET         8'h00

`define GUARD_QUARTER_BASE 15'h6000
`define GUARD_HALF_BASE    15'h4000

`define MEM_ADDR_W   15
`define FIFO_DEPTH   16
`define LAST_BIT_IDX 3'h7

`endif

/* File: spi_nvsram_pkg.sv */
// Types shared by the serial nvSRAM command block and its write buffer.
package spi_nvsram_pkg;

    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,
        ST_OPCODE = 8'h02,
        ST_ADDR   = 8'h04,
        ST_WDATA  = 8'h08,
        ST_RDATA  = 8'h10,
        ST_STAT_W = 8'h20,
        ST_STAT_R = 8'h40,
        ST_IGNORE = 8'h80
    } state_t;

    typedef struct packed {
        logic       pin_guard;
        logic [2:0] spare;
        logic       guard_hi;
        logic       guard_lo;
        logic       wel;
        logic       busy;
    } status_t;

    typedef struct packed {
        logic [14:0] addr;
        logic [7:0]  data;
    } mem_wr_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic guard_n;
    } pins_t;

endpackage : spi_nvsram_pkg

/* File: testbench.sv */
// Self-checking bench for the serial nvSRAM command, status and guard block.
`timescale 1ns/1ps
module testbench;
    logic        clk_i;
    logic        rst_n_i;
    logic        cs_n, sck, si, so, so_oe_n, act, stby, save_rq, rest_rq;
    logic        asave, rd_req, wr_valid, ovf;
    logic        guard_n = 1'b1, rdy = 1'b1, oe_seen = 1'b0, act_seen = 1'b0;
    logic [14:0] rd_addr;
    logic [7:0]  rd_data = 8'h00, st;
    logic [7:0]  nv_st;
    logic [7:0]  rst_st = 8'h00;
    logic        rld = 1'b0;
    logic [8:0]  bcnt = 9'h000;
    logic [22:0] wr_word;
    logic [22:0] wq[$];
    logic [31:0] rx;
    int          n_errors = 0, total_checks = 0, n_save = 0, n_rest = 0;

    spi_master_model m (.clk_i(clk_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so));

    spi_nvsram_cmd_status_protect i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .guard_pin_n_i(guard_n), .so_o(so), .so_oe_n_o(so_oe_n), .active_o(act),
        .standby_o(stby), .nv_busy_i(bcnt != 9'h000), .save_req_o(save_rq),
        .restore_req_o(rest_rq), .autosave_en_o(asave), .nv_status_o(nv_st),
        .restore_status_i(rst_st), .restore_load_i(rld), .mem_rd_req_o(rd_req),
        .mem_rd_addr_o(rd_addr), .mem_rd_data_i(rd_data), .mem_wr_valid_o(wr_valid),
        .mem_wr_o(wr_word), .mem_wr_ready_i(rdy), .wr_overflow_o(ovf)
    );

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Save engine, memory and line watchers.
    always @(posedge clk_i) begin
        if (save_rq === 1'b1 || rest_rq === 1'b1) begin
            bcnt <= 9'h12C;
        end else if (bcnt != 9'h000) begin
            bcnt <= bcnt - 9'h001;
        end
        if (save_rq === 1'b1) n_save <= n_save + 1;
        if (rest_rq === 1'b1) n_rest <= n_rest + 1;
        if (rd_req === 1'b1) rd_data <= rd_addr[7:0] ^ 8'h5A;
        if (wr_valid === 1'b1 && rdy) wq.push_back(wr_word);
        if (!cs_n && so_oe_n === 1'b0) oe_seen <= 1'b1;
        if (!cs_n && act === 1'b1) act_seen <= 1'b1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : check

    task automatic close_out();
        if (n_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out

    task automatic op(input logic [7:0] c);
        m.xfer({24'h0, c}, 8, 1'b0, rx);
    endtask : op

    task automatic status_read_cmd();
        m.xfer({16'h0, 8'h05, 8'h00}, 16, 1'b0, rx);
        st = rx[7:0];
    endtask : status_read_cmd

    task automatic status_write_cmd(input logic [7:0] v);
        op(8'h06);
        m.xfer({16'h0, 8'h01, v}, 16, 1'b0, rx);
    endtask : status_write_cmd

    task automatic wait_idle();
        for (int i = 0; i < 1000 && stby !== 1'b1; i++) @(posedge clk_i);
        check(stby, 1'b1, "standby after busy");
        if (stby !== 1'b1) close_out();
    endtask : wait_idle

    task automatic t_reset_latch();
        check(stby, 1'b1, "standby after reset");
        status_read_cmd();
        check(st, 8'h00, "status after reset");
        check(oe_seen, 1'b1, "SO driven on status read");
        op(8'h06);
        status_read_cmd();
        check(st, 8'h02, "latch set");
        op(8'h04);
        status_read_cmd();
        check(st, 8'h00, "latch cleared");
    endtask : t_reset_latch

    task automatic t_status();
        m.xfer({16'h0, 8'h01, 8'hFF}, 16, 1'b0, rx);
        status_read_cmd();
        check(st, 8'h00, "write without latch");
        status_write_cmd(8'hFF);
        status_read_cmd();
        check(st, 8'h8C, "status write");
        check(nv_st, 8'h8C, "status copy for save");
        op(8'h06);
        m.xfer({20'h0, 8'h01, 4'h0}, 12, 1'b0, rx);
        status_read_cmd();
        check(st, 8'h8E, "short status write");
        op(8'h04);
        guard_n <= 1'b0;
        status_write_cmd(8'h00);
        status_read_cmd();
        check(st, 8'h8C, "pin guarded write");
        guard_n <= 1'b1;
        status_write_cmd(8'h00);
        status_read_cmd();
        check(st, 8'h00, "pin released write");
    endtask : t_status

    task automatic t_mem();
        status_write_cmd(8'h04);
        op(8'h06);
        wq.delete();
        m.xfer({8'h02, 16'h5FFF, 8'hA1}, 32, 1'b1, rx);
        m.xfer(32'hB2, 8, 1'b0, rx);
        check(wq.size(), 1, "guarded burst count");
        check(wq[0], {15'h5FFF, 8'hA1}, "burst word");
        status_read_cmd();
        check(st, 8'h04, "latch after write");
        status_write_cmd(8'h00);
        rdy <= 1'b0;
        op(8'h06);
        wq.delete();
        m.xfer({8'h02, 16'h0000}, 24, 1'b1, rx);
        for (int i = 0; i < 20; i++) m.xfer(i, 8, i < 19, rx);
        check(ovf, 1'b1, "buffer overflow");
        rdy <= 1'b1;
        for (int i = 0; i < 300 && wq.size() < 16; i++) @(posedge clk_i);
        check(wq.size() >= 16, 1, "drained words");
        check(wq[0], 23'h0, "first drained word");
        m.xfer({8'h03, 16'h7FFF}, 24, 1'b1, rx);
        m.xfer(32'h0, 16, 1'b0, rx);
        check(rx[15:0], 16'hA55A, "burst read wrap");
    endtask : t_mem

    task automatic t_nv();
        op(8'h3C);
        check(n_save, 0, "save without latch");
        op(8'h06);
        op(8'h3C);
        check(n_save, 1, "save request");
        check(stby, 1'b0, "standby held while busy");
        status_read_cmd();
        check(st, 8'h01, "busy during save");
        wait_idle();
        op(8'h06);
        op(8'h60);
        check(n_rest, 1, "restore request");
        wait_idle();
        status_read_cmd();
        check(st, 8'h00, "busy cleared");
        rst_st <= 8'h8C;
        rld    <= 1'b1;
        @(posedge clk_i);
        rld    <= 1'b0;
        status_read_cmd();
        check(st, 8'h8C, "restored guard bits");
        op(8'h06);
        op(8'h19);
        check(asave, 1'b0, "autosave off");
        op(8'h06);
        op(8'h59);
        check(asave, 1'b1, "autosave on");
        oe_seen = 1'b0;
        act_seen = 1'b0;
        m.xfer({16'h0, 8'h1E, 8'hFF}, 16, 1'b0, rx);
        check(oe_seen, 1'b0, "output driven after reserved code");
        check(act_seen, 1'b1, "active while selected");
    endtask : t_nv

    initial begin
        rst_n_i = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        t_reset_latch();
        t_status();
        t_mem();
        t_nv();
        close_out();
    end
endmodule : testbench
